// ### common/fsrc_pkg.sv
/*
 * Constants, field layouts and checksum functions for the flow sensor read formatter.
 * Assumes: included first in compile order; no other dependencies.
 */
package fsrc_pkg;

	// ----------------------------------------------------------------
	// data path sizes
	// ----------------------------------------------------------------
	localparam int WORD_W     = 16;
	localparam int FIFO_DEPTH = 32;

	// ----------------------------------------------------------------
	// checksum definition
	// ----------------------------------------------------------------
	localparam logic [7:0]  CRC_POLY        = 8'h31;
	localparam logic [7:0]  CRC_INIT        = 8'hFF;
	localparam logic [7:0]  CRC_XOROUT      = 8'h00;
	localparam logic [15:0] CRC_CHECK_WORD  = 16'hBEEF;
	localparam logic [7:0]  CRC_CHECK_VALUE = 8'h92;

	// ----------------------------------------------------------------
	// word kinds and flow-unit layout
	// ----------------------------------------------------------------
	localparam logic [1:0]  KIND_FLOW     = 2'h0;
	localparam logic [1:0]  KIND_TEMP     = 2'h1;
	localparam logic [1:0]  KIND_UNIT     = 2'h2;
	localparam int          PREFIX_LSB    = 0;
	localparam int          TIMEBASE_LSB  = 4;
	localparam int          BASE_LSB      = 8;
	localparam int          SPARE_LSB     = 13;
	localparam logic [3:0]  PREFIX_ONE    = 4'h8;
	localparam logic [3:0]  TIMEBASE_MIN  = 4'h4;
	localparam logic [4:0]  BASE_STD_LTR  = 5'h01;
	localparam logic [2:0]  SPARE_BITS    = 3'h0;
	localparam logic [15:0] UNIT_CODE_SLM = {SPARE_BITS, BASE_STD_LTR, TIMEBASE_MIN, PREFIX_ONE};

	// ----------------------------------------------------------------
	// link byte order
	// ----------------------------------------------------------------
	localparam logic [1:0] BYTE_MSB  = 2'h0;
	localparam logic [1:0] BYTE_LSB  = 2'h1;
	localparam logic [1:0] BYTE_CRC  = 2'h2;
	localparam logic [7:0] IDLE_BYTE = 8'hFF;

	function automatic logic [7:0] fsrcCrcByte(input logic [7:0] crcIn, input logic [7:0] dataByte);
		logic [7:0] c;
		c = crcIn ^ dataByte;
		for (int i = 0; i < 8; i++) begin
			c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
		end
		return c;
	endfunction

	function automatic logic [7:0] fsrcCrcWord(input logic [15:0] w);
		return fsrcCrcByte(fsrcCrcByte(CRC_INIT, w[15:8]), w[7:0]) ^ CRC_XOROUT;
	endfunction

endpackage

// ### core/fsrc_crc8.sv
/*
 * One-cycle checksum engine over a 16-bit word, result registered.
 * Assumes: start is a one-cycle pulse on sys_clk; dataWord valid with it.
 */
`timescale 1ns/1ps
module fsrc_crc8 (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic        start,
	input  wire logic [15:0] dataWord,
	output logic             done,
	output logic [7:0]       crcOut
);
	typedef struct packed {
		logic       done;
		logic [7:0] crc;
	} fsrc_crc_t;

	fsrc_crc_t q;
	fsrc_crc_t d;

	always_comb begin
		d      = q;
		d.done = start;
		if (start) begin
			d.crc = fsrc_pkg::fsrcCrcWord(dataWord);
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign done   = q.done;
	assign crcOut = q.crc;

	crc_known_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		start && dataWord == fsrc_pkg::CRC_CHECK_WORD |=> crcOut == fsrc_pkg::CRC_CHECK_VALUE)
		else $error("checksum of check word wrong");

	crc_latency_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		start |=> done ##1 (done == $past(start)))
		else $error("checksum result not one cycle after start");
endmodule

// ### core/fsrc_fifo.sv
/*
 * Word FIFO with registered read data and registered full flag.
 * Assumes: single clock; consumer holds outReady as it likes.
 */
`timescale 1ns/1ps
module fsrc_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	input  wire logic             sys_clk,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic [WIDTH-1:0]      outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam int CNT_W = $clog2(DEPTH + 1);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PTR_W-1:0]            wrPtr;
		logic [PTR_W-1:0]            rdPtr;
		logic [CNT_W-1:0]            count;
		logic                        inReady;
		logic                        outValid;
		logic [WIDTH-1:0]            outData;
	} fsrc_fifo_t;

	fsrc_fifo_t q;
	fsrc_fifo_t d;
	logic       push;
	logic       load;

	always_comb begin
		d    = q;
		push = inValid && q.inReady;
		load = (!q.outValid || outReady) && (q.count != '0);
		if (push) begin
			d.mem[q.wrPtr] = inData;
			d.wrPtr = (q.wrPtr == PTR_W'(DEPTH - 1)) ? '0 : q.wrPtr + 1'b1;
		end
		if (load) begin
			d.outData  = q.mem[q.rdPtr];
			d.outValid = 1'b1;
			d.rdPtr = (q.rdPtr == PTR_W'(DEPTH - 1)) ? '0 : q.rdPtr + 1'b1;
		end else if (outReady) begin
			d.outValid = 1'b0;
		end
		d.count   = q.count + CNT_W'(push) - CNT_W'(load);
		d.inReady = (d.count != CNT_W'(DEPTH));
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign inReady  = q.inReady;
	assign outData  = q.outData;
	assign outValid = q.outValid;

	fifo_level_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		q.count <= CNT_W'(DEPTH) && (q.count != CNT_W'(DEPTH) || !inReady))
		else $error("fifo level or full flag wrong");
endmodule

// ### core/fsrc_top.sv
/*
 * Read-word formatter: buffers flow, temperature and unit words, appends
 * the 8-bit checksum and hands three-byte frames to the link byte engine.
 * Assumes: word source on sys_clk; byte requests come from link logic on
 * linkClk; the two clocks are unrelated; nrst resets both domains.
 */
// Summary of operation
// - checksum byte follows each two-byte word
// - only read data carries checksums
// - polynomial 0x31, leading term implicit
// - preset all ones, no reflection, no inversion
// - flow word is signed sixteen bit
// - temperature word is signed sixteen bit
// - unit word: prefix, time base, base
// - standard liters per minute report 0x0148
`timescale 1ns/1ps
module fsrc_top #(
	parameter int WORD_W     = fsrc_pkg::WORD_W,
	parameter int FIFO_DEPTH = fsrc_pkg::FIFO_DEPTH
) (
	input  wire logic        sys_clk,
	input  wire logic        nrst,
	input  wire logic [15:0] wordData,
	input  wire logic [1:0]  wordKind,
	input  wire logic        wordValid,
	output logic             wordReady,
	output logic [15:0]      frameCount,
	output logic             linkBusy,
	input  wire logic        linkClk,
	input  wire logic        linkByteReq,
	output logic [7:0]       txByte,
	output logic             txByteValid,
	output logic             txIsCrc,
	output logic             txUnderrun
);
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		FSRC_IDLE,
		FSRC_CRC,
		FSRC_WAIT
	} fsrc_state_t;

	typedef struct packed {
		fsrc_state_t state;
		logic [15:0] word;
		logic [7:0]  crc;
		logic        crcGo;
		logic        reqTog;
		logic        ackSync1;
		logic        ackSync2;
		logic        ackSync3;
		logic        busySync1;
		logic        busySync2;
		logic        busySync3;
		logic        linkBusy;
		logic [15:0] frameCount;
	} fsrc_sys_t;

	typedef struct packed {
		logic        reqSync1;
		logic        reqSync2;
		logic        reqSync3;
		logic        ackTog;
		logic [23:0] frame;
		logic        haveFrame;
		logic [1:0]  byteIdx;
		logic [7:0]  txByte;
		logic        txValid;
		logic        txIsCrc;
		logic        txUnderrun;
	} fsrc_link_t;

	function automatic logic [7:0] frameByte(input logic [23:0] f, input logic [1:0] idx);
		case (idx)
			fsrc_pkg::BYTE_MSB: frameByte = f[23:16];
			fsrc_pkg::BYTE_LSB: frameByte = f[15:8];
			default:            frameByte = f[7:0];
		endcase
	endfunction

	fsrc_sys_t   sq;
	fsrc_sys_t   sd;
	fsrc_link_t  lq;
	fsrc_link_t  ld;
	logic [15:0] fifoInData;
	logic [15:0] fifoOutData;
	logic        fifoOutValid;
	logic        fifoOutReady;
	logic        crcDone;
	logic [7:0]  crcOut;
	logic [23:0] sysFrame;

	// ----------------------------------------------------------------
	// word formatting at the input
	// ----------------------------------------------------------------
	always_comb begin
		if (wordKind == fsrc_pkg::KIND_UNIT) begin
			fifoInData = fsrc_pkg::UNIT_CODE_SLM;
		end else begin
			fifoInData = wordData;
		end
	end

	fsrc_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (FIFO_DEPTH)
	) fsrc_fifo_inst (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.inData   (fifoInData),
		.inValid  (wordValid),
		.inReady  (wordReady),
		.outData  (fifoOutData),
		.outValid (fifoOutValid),
		.outReady (fifoOutReady)
	);

	fsrc_crc8 fsrc_crc8_inst (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.start    (sq.crcGo),
		.dataWord (sq.word),
		.done     (crcDone),
		.crcOut   (crcOut)
	);

	// ----------------------------------------------------------------
	// system domain: checksum and frame hand-off
	// ----------------------------------------------------------------
	assign fifoOutReady = (sq.state == FSRC_IDLE);
	assign sysFrame     = {sq.word, sq.crc};

	always_comb begin
		sd           = sq;
		sd.crcGo     = 1'b0;
		sd.ackSync1  = lq.ackTog;
		sd.ackSync2  = sq.ackSync1;
		sd.ackSync3  = sq.ackSync2;
		sd.busySync1 = lq.haveFrame;
		sd.busySync2 = sq.busySync1;
		sd.busySync3 = sq.busySync2;
		if (sq.busySync2 == sq.busySync3) begin
			sd.linkBusy = sq.busySync3;
		end
		case (sq.state)
			FSRC_IDLE: begin
				if (fifoOutValid) begin
					sd.word  = fifoOutData;
					sd.crcGo = 1'b1;
					sd.state = FSRC_CRC;
				end
			end
			FSRC_CRC: begin
				if (crcDone) begin
					sd.crc    = crcOut;
					sd.reqTog = ~sq.reqTog;
					sd.state  = FSRC_WAIT;
				end
			end
			FSRC_WAIT: begin
				if (sq.ackSync2 == sq.ackSync3 && sq.ackSync3 == sq.reqTog) begin
					sd.frameCount = sq.frameCount + 16'h0001;
					sd.state      = FSRC_IDLE;
				end
			end
			default: begin
				sd.state = FSRC_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			sq <= '0;
		end else begin
			sq <= sd;
		end
	end

	assign frameCount = sq.frameCount;
	assign linkBusy   = sq.linkBusy;

	// ----------------------------------------------------------------
	// link domain: byte serving
	// ----------------------------------------------------------------
	always_comb begin
		ld            = lq;
		ld.txValid    = 1'b0;
		ld.txIsCrc    = 1'b0;
		ld.txUnderrun = 1'b0;
		ld.reqSync1   = sq.reqTog;
		ld.reqSync2   = lq.reqSync1;
		ld.reqSync3   = lq.reqSync2;
		if (linkByteReq) begin
			ld.txValid = 1'b1;
			if (lq.haveFrame) begin
				ld.txByte = frameByte(lq.frame, lq.byteIdx);
				if (lq.byteIdx == fsrc_pkg::BYTE_CRC) begin
					ld.txIsCrc   = 1'b1;
					ld.haveFrame = 1'b0;
					ld.byteIdx   = fsrc_pkg::BYTE_MSB;
				end else begin
					ld.byteIdx = lq.byteIdx + 2'h1;
				end
			end else begin
				// nothing queued: released bus reads as all ones
				ld.txByte     = fsrc_pkg::IDLE_BYTE;
				ld.txUnderrun = 1'b1;
			end
		end
		if (!lq.haveFrame && lq.reqSync2 == lq.reqSync3 && lq.reqSync3 != lq.ackTog) begin
			ld.frame     = sysFrame;
			ld.haveFrame = 1'b1;
			ld.byteIdx   = fsrc_pkg::BYTE_MSB;
			ld.ackTog    = lq.reqSync3;
		end
	end

	always_ff @(posedge linkClk or negedge nrst) begin
		if (!nrst) begin
			lq <= '0;
		end else begin
			lq <= ld;
		end
	end

	assign txByte      = lq.txByte;
	assign txByteValid = lq.txValid;
	assign txIsCrc     = lq.txIsCrc;
	assign txUnderrun  = lq.txUnderrun;

	// ----------------------------------------------------------------
	// checks: system domain
	// ----------------------------------------------------------------
	unit_code_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		wordValid && wordReady && wordKind == fsrc_pkg::KIND_UNIT
		|-> fifoInData[12:8] == 5'h01 && fifoInData[7:4] == 4'h4 && fifoInData[3:0] == 4'h8)
		else $error("unit word fields wrong");

	unit_spare_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		wordValid && wordReady && wordKind == fsrc_pkg::KIND_UNIT
		|-> fifoInData[15:fsrc_pkg::SPARE_LSB] == fsrc_pkg::SPARE_BITS)
		else $error("unit word spare bits set");

	word_pass_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		wordValid && wordReady && wordKind != fsrc_pkg::KIND_UNIT |-> fifoInData == wordData)
		else $error("measurement word altered");

	frame_crc_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		$changed(sq.reqTog) |-> sq.crc == fsrc_pkg::fsrcCrcWord(sq.word))
		else $error("frame checksum does not match its word");

	frame_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		sq.state == FSRC_WAIT |=> $stable(sq.word) && $stable(sq.crc))
		else $error("frame changed during hand-off");

	crc_turn_a: assert property (@(posedge sys_clk) disable iff (!nrst)
		sq.crcGo |-> sq.state == FSRC_CRC ##2 sq.state == FSRC_WAIT)
		else $error("checksum step not two cycles");

	// ----------------------------------------------------------------
	// checks: link domain
	// ----------------------------------------------------------------
	crc_byte_a: assert property (@(posedge linkClk) disable iff (!nrst)
		txByteValid && txIsCrc |-> txByte == fsrc_pkg::fsrcCrcWord(lq.frame[23:8]))
		else $error("checksum byte wrong");

	byte_seq_a: assert property (@(posedge linkClk) disable iff (!nrst)
		linkByteReq && lq.haveFrame && lq.byteIdx == fsrc_pkg::BYTE_LSB
		|=> txByteValid && !txIsCrc && txByte == lq.frame[15:8])
		else $error("low data byte out of order");

	read_only_a: assert property (@(posedge linkClk) disable iff (!nrst)
		txByteValid |-> $past(linkByteReq))
		else $error("byte sent without read request");

	idle_fill_a: assert property (@(posedge linkClk) disable iff (!nrst)
		txUnderrun |-> txByte == fsrc_pkg::IDLE_BYTE && !txIsCrc && txByteValid)
		else $error("underrun byte malformed");
endmodule

// ### verif/flow_sensor_read_crc_format_bench.sv
/*
 * Self-checking bench: random and corner words in, frames checked out.
 * Assumes: design files and package compiled before this file.
 */
`timescale 1ns/1ps
module flow_sensor_read_crc_format_bench;
	logic        sys_clk;
	logic        linkClk;
	logic        nrst;
	logic [15:0] wordData;
	logic [1:0]  wordKind;
	logic        wordValid;
	logic        wordReady;
	logic [15:0] frameCount;
	logic        linkBusy;
	logic        linkByteReq;
	logic [7:0]  txByte;
	logic        txByteValid;
	logic        txIsCrc;
	logic        txUnderrun;
	logic        run;
	logic [1:0]  gap;
	logic        frmValid;
	logic [15:0] frmWord;
	logic [7:0]  frmCrc;
	logic        frmOk;
	int          undCount;
	logic [15:0] expQ[$];
	int          errCount;
	int          testsRun;
	int          total;
	int          cyc;
	int          n;

	fsrc_top fsrc_top_inst (
		.sys_clk(sys_clk), .nrst(nrst), .wordData(wordData), .wordKind(wordKind),
		.wordValid(wordValid), .wordReady(wordReady), .frameCount(frameCount),
		.linkBusy(linkBusy), .linkClk(linkClk), .linkByteReq(linkByteReq),
		.txByte(txByte), .txByteValid(txByteValid), .txIsCrc(txIsCrc),
		.txUnderrun(txUnderrun)
	);

	fsrc_host_model fsrc_host_model_inst (
		.linkClk(linkClk), .nrst(nrst), .run(run), .gap(gap),
		.linkByteReq(linkByteReq), .txByte(txByte), .txByteValid(txByteValid),
		.txIsCrc(txIsCrc), .txUnderrun(txUnderrun), .frmValid(frmValid),
		.frmWord(frmWord), .frmCrc(frmCrc), .frmOk(frmOk), .undCount(undCount)
	);

	initial sys_clk = 1'b0;
	always #10 sys_clk = ~sys_clk;
	initial begin
		linkClk = 1'b0;
		#2.5;
		forever #6 linkClk = ~linkClk;
	end

	// ----------------------------------------------------------------
	// compare tasks and closing
	// ----------------------------------------------------------------
	task automatic checkWord(input logic [15:0] got, input logic [15:0] exp);
		testsRun++;
		if (got !== exp) begin
			errCount++;
			$display("[ERR] %0t word got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic checkByte(input logic [7:0] got, input logic [7:0] exp);
		testsRun++;
		if (got !== exp) begin
			errCount++;
			$display("[ERR] %0t byte got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic checkBit(input logic got, input logic exp);
		testsRun++;
		if (got !== exp) begin
			errCount++;
			$display("[ERR] %0t flag got %b exp %b", $time, got, exp);
		end
	endtask

	task automatic close_out;
		if (errCount == 0 && testsRun > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	function automatic logic [15:0] expWord(input logic [15:0] d, input logic [1:0] k);
		return (k == 2'h2) ? 16'h0148 : d;
	endfunction

	// host conversion of raw words to physical units
	function automatic int flowSlm(input logic [15:0] raw);
		return (int'(signed'(raw)) + 24576) / 170;
	endfunction

	function automatic int tempDeg(input logic [15:0] raw);
		return int'(signed'(raw)) / 200;
	endfunction

	// offer one word; valid stays up so the next call runs back to back
	task automatic sendWord(input logic [15:0] d, input logic [1:0] k);
		@(negedge sys_clk);
		wordData = d;
		wordKind = k;
		wordValid = 1'b1;
		while (wordReady !== 1'b1) @(negedge sys_clk);
		@(posedge sys_clk);
		expQ.push_back(expWord(d, k));
		total++;
	endtask

	task automatic drain;
		int w;
		w = 0;
		while (expQ.size() != 0 && w < 3000) begin
			@(negedge sys_clk);
			w++;
		end
		checkWord(16'(expQ.size()), 16'h0000);
		repeat (20) @(negedge sys_clk);
	endtask

	// ----------------------------------------------------------------
	// frame and underrun checks
	// ----------------------------------------------------------------
	always @(negedge linkClk) begin
		if (frmValid === 1'b1) begin
			if (expQ.size() == 0) checkBit(1'b1, 1'b0);
			else checkWord(frmWord, expQ.pop_front());
			checkBit(frmOk, 1'b1);
			if (frmWord === 16'hBEEF) checkByte(frmCrc, 8'h92);
			if (frmWord === 16'hE268) checkWord(16'(flowSlm(frmWord)), 16'h0064);
			if (frmWord === 16'h1388) checkWord(16'(tempDeg(frmWord)), 16'h0019);
		end
		if (txUnderrun === 1'b1) checkByte(txByte, 8'hFF);
	end

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			errCount++;
			close_out();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h92FC));
		nrst = 1'b0;
		wordData = 16'h0000;
		wordKind = 2'h0;
		wordValid = 1'b0;
		run = 1'b0;
		gap = 2'h0;
		repeat (16) @(negedge sys_clk);
		checkBit(wordReady, 1'b0);
		checkBit(txByteValid, 1'b0);
		checkWord(frameCount, 16'h0000);
		nrst = 1'b1;
		run = 1'b1;
		repeat (10) @(negedge sys_clk);
		checkBit(logic'(undCount > 0), 1'b1);
		// signed boundaries, the check word and every kind
		sendWord(16'hBEEF, 2'h0);
		sendWord(16'h8000, 2'h0);
		sendWord(16'h7FFF, 2'h0);
		sendWord(16'h8000, 2'h1);
		sendWord(16'h7FFF, 2'h1);
		sendWord(16'hFFFF, 2'h2);
		sendWord(16'h0000, 2'h3);
		sendWord(16'hE268, 2'h0);
		sendWord(16'h1388, 2'h1);
		for (int i = 0; i < 40; i++) begin
			gap = 2'($urandom);
			sendWord(16'($urandom), 2'($urandom));
		end
		@(negedge sys_clk);
		wordValid = 1'b0;
		drain();
		// host stalls: fill until refused, then drain
		run = 1'b0;
		gap = 2'h0;
		n = 0;
		while (wordReady === 1'b1 && n < 40) begin
			sendWord(16'($urandom), 2'h1);
			@(negedge sys_clk);
			wordValid = 1'b0;
			n++;
		end
		checkBit(logic'(n >= 32 && n <= 35), 1'b1);
		checkBit(linkBusy, 1'b1);
		run = 1'b1;
		drain();
		checkWord(frameCount, 16'(total));
		checkBit(linkBusy, 1'b0);
		close_out();
	end
endmodule

// ### verif/fsrc_host_model.sv
/*
 * Host reader model: pulls bytes from the link one at a time, rebuilds
 * frames and rechecks each checksum.
 * Assumes: linkClk and nrst from the bench; run and gap set by the bench.
 */
`timescale 1ns/1ps
module fsrc_host_model (
	input  wire logic       linkClk,
	input  wire logic       nrst,
	input  wire logic       run,
	input  wire logic [1:0] gap,
	output logic            linkByteReq,
	input  wire logic [7:0] txByte,
	input  wire logic       txByteValid,
	input  wire logic       txIsCrc,
	input  wire logic       txUnderrun,
	output logic            frmValid,
	output logic [15:0]     frmWord,
	output logic [7:0]      frmCrc,
	output logic            frmOk,
	output int              undCount
);
	logic        pend;
	logic [1:0]  idx;
	logic [1:0]  waitN;
	logic [15:0] hold;

	function automatic logic [7:0] crcOf(input logic [15:0] w);
		logic [7:0] c;
		c = 8'hFF;
		for (int i = 15; i >= 0; i--) begin
			c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h31 : 8'h00);
		end
		return c;
	endfunction

	// ----------------------------------------------------------------
	// byte requests and frame rebuild
	// ----------------------------------------------------------------
	always @(posedge linkClk or negedge nrst) begin
		if (!nrst) begin
			linkByteReq <= 1'b0;
			pend <= 1'b0;
			idx <= 2'h0;
			waitN <= 2'h0;
			frmValid <= 1'b0;
			undCount <= 0;
		end else begin
			frmValid <= 1'b0;
			linkByteReq <= 1'b0;
			if (txByteValid) begin
				pend <= 1'b0;
				if (txUnderrun) begin
					undCount <= undCount + 1;
				end else if (idx == 2'h2) begin
					// msb first, checksum last
					frmWord <= hold;
					frmCrc <= txByte;
					frmOk <= (crcOf(hold) == txByte) && txIsCrc;
					frmValid <= 1'b1;
					idx <= 2'h0;
				end else begin
					hold <= {hold[7:0], txByte};
					idx <= idx + 2'h1;
				end
			end else if (!pend && run) begin
				if (waitN != 2'h0) begin
					waitN <= waitN - 2'h1;
				end else begin
					linkByteReq <= 1'b1;
					pend <= 1'b1;
					waitN <= gap;
				end
			end
		end
	end
endmodule
